/* rtl/trim_dac_code_limit_control.sv */
// design: register file, code clamping and safety disable of three trim converter channels
// Summary of operation
// - each channel holds an 8-bit read/write code; 0x7F is midscale
// - code above the upper limit is replaced by the upper limit
// - code below the lower limit and not above the upper limit is replaced by the lower limit
// - lower limit above upper limit holds the channel output disabled
// - control bit 2 enables the output; bits 7 to 3 unused, read zero
// - control bits 1:0 pick midscale voltage 1.25, 1.0, 0.8 or 0.6 V
`timescale 1ns/1ps
`default_nettype none

module trim_dac_code_limit_control (
  // clock and synchronous reset
  input  wire logic                                       MCLK,
  input  wire logic                                       RST,
  // register port behind the serial management interface
  input  wire logic [7:0]                                 REG_ADDR,
  input  wire logic                                       REG_WR,
  input  wire logic [7:0]                                 REG_WDATA,
  input  wire logic                                       REG_RD,
  output logic      [7:0]                                 REG_RDATA,
  // drive toward the converter stages, index 0 is channel 4
  output trim_dac_pkg::trim_out_t [trim_dac_pkg::NUM_CH-1:0] TRIM_OUT
);

  trim_dac_pkg::trim_state_t st_ff;
  trim_dac_pkg::trim_state_t nxt_st;

  // unsigned clamp of a code between two limits; upper limit checked first
  function automatic logic [7:0] clamp_code(input logic [7:0] code,
                                            input logic [7:0] hi,
                                            input logic [7:0] lo);
    logic [7:0] res;
    res = code;
    if (code > hi) begin
      res = hi;
    end else if (code < lo) begin
      res = lo;
    end
    return res;
  endfunction

  // read data for one address; reserved control bits and unmapped addresses read zero
  function automatic logic [7:0] read_reg(input trim_dac_pkg::chan_regs_t [trim_dac_pkg::NUM_CH-1:0] r,
                                          input logic [7:0] addr);
    logic [7:0] d;
    d = trim_dac_pkg::UNMAPPED_DATA;
    for (int i = 0; i < trim_dac_pkg::NUM_CH; i++) begin
      if (addr == trim_dac_pkg::CTRL_OFS[i]) begin
        d = {5'h00, r[i].trim_output_enable, r[i].midscale_voltage_select};
      end else if (addr == trim_dac_pkg::CODE_OFS[i]) begin
        d = r[i].trim_code_bits;
      end else if (addr == trim_dac_pkg::HI_OFS[i]) begin
        d = r[i].high_limit;
      end else if (addr == trim_dac_pkg::LO_OFS[i]) begin
        d = r[i].low_limit;
      end
    end
    return d;
  endfunction

  // next state: register writes, then outputs computed from the freshly written values
  // so the applied code and disable follow a write on the same edge that stores it
  always_comb begin
    nxt_st = st_ff;
    for (int i = 0; i < trim_dac_pkg::NUM_CH; i++) begin
      if (REG_WR && REG_ADDR == trim_dac_pkg::CTRL_OFS[i]) begin
        nxt_st.regs[i].trim_output_enable      = REG_WDATA[trim_dac_pkg::CTRL_EN_BIT];
        nxt_st.regs[i].midscale_voltage_select =
          trim_dac_pkg::midscale_voltage_select_t'(REG_WDATA[trim_dac_pkg::CTRL_SEL_MSB:0]);
      end
      if (REG_WR && REG_ADDR == trim_dac_pkg::CODE_OFS[i]) begin
        nxt_st.regs[i].trim_code_bits = REG_WDATA;
      end
      if (REG_WR && REG_ADDR == trim_dac_pkg::HI_OFS[i]) begin
        nxt_st.regs[i].high_limit = REG_WDATA;
      end
      if (REG_WR && REG_ADDR == trim_dac_pkg::LO_OFS[i]) begin
        nxt_st.regs[i].low_limit = REG_WDATA;
      end
      // outputs from the updated registers
      nxt_st.outs[i].code = clamp_code(nxt_st.regs[i].trim_code_bits,
                                       nxt_st.regs[i].high_limit,
                                       nxt_st.regs[i].low_limit);
      // inverted limits force the stage off whatever the enable says
      nxt_st.outs[i].enable = nxt_st.regs[i].trim_output_enable &&
                              !(nxt_st.regs[i].low_limit > nxt_st.regs[i].high_limit);
      nxt_st.outs[i].midscale_voltage_select = nxt_st.regs[i].midscale_voltage_select;
    end
    // read data is sampled before any same-cycle write lands
    if (REG_RD) begin
      nxt_st.rdata = read_reg(st_ff.regs, REG_ADDR);
    end
  end

  // state register; reset leaves every channel off at midscale with wide-open limits
  always_ff @(posedge MCLK) begin
    if (RST) begin
      for (int i = 0; i < trim_dac_pkg::NUM_CH; i++) begin
        st_ff.regs[i].trim_code_bits          <= trim_dac_pkg::MIDSCALE_CODE;
        st_ff.regs[i].high_limit              <= trim_dac_pkg::HI_RESET;
        st_ff.regs[i].low_limit               <= trim_dac_pkg::LO_RESET;
        st_ff.regs[i].trim_output_enable      <= 1'b0;
        st_ff.regs[i].midscale_voltage_select <= trim_dac_pkg::MID_1V25;
        st_ff.outs[i].code                    <= trim_dac_pkg::MIDSCALE_CODE;
        st_ff.outs[i].enable                  <= 1'b0;
        st_ff.outs[i].midscale_voltage_select <= trim_dac_pkg::MID_1V25;
      end
      st_ff.rdata <= trim_dac_pkg::UNMAPPED_DATA;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign REG_RDATA = st_ff.rdata;
  assign TRIM_OUT  = st_ff.outs;

  // checks, one set per channel
  for (genvar g = 0; g < trim_dac_pkg::NUM_CH; g++) begin : g_chk

    property p_code_readback;
      @(posedge MCLK) disable iff (RST)
        (REG_WR && REG_ADDR == trim_dac_pkg::CODE_OFS[g]) ##1 !REG_WR ##1
        (REG_RD && !REG_WR && REG_ADDR == trim_dac_pkg::CODE_OFS[g])
        |=> (REG_RDATA == $past(REG_WDATA, 3));
    endproperty
    a_code_readback: assert property (p_code_readback)
      else $error("code register does not read back what was written");

    property p_clamp_high;
      @(posedge MCLK) disable iff (RST)
        (st_ff.regs[g].trim_code_bits > st_ff.regs[g].high_limit)
        |-> (TRIM_OUT[g].code == st_ff.regs[g].high_limit);
    endproperty
    a_clamp_high: assert property (p_clamp_high)
      else $error("code above upper limit not clamped");

    property p_clamp_low;
      @(posedge MCLK) disable iff (RST)
        (st_ff.regs[g].trim_code_bits < st_ff.regs[g].low_limit &&
         st_ff.regs[g].low_limit <= st_ff.regs[g].high_limit)
        |-> (TRIM_OUT[g].code == st_ff.regs[g].low_limit);
    endproperty
    a_clamp_low: assert property (p_clamp_low)
      else $error("code below lower limit not clamped");

    property p_inverted_limits_off;
      @(posedge MCLK) disable iff (RST)
        (REG_WR && REG_ADDR == trim_dac_pkg::LO_OFS[g] && REG_WDATA > st_ff.regs[g].high_limit)
        |=> !TRIM_OUT[g].enable;
    endproperty
    a_inverted_limits_off: assert property (p_inverted_limits_off)
      else $error("output enabled with lower limit above upper limit");

    property p_enable_follows_bit;
      @(posedge MCLK) disable iff (RST)
        (REG_WR && REG_ADDR == trim_dac_pkg::CTRL_OFS[g] &&
         st_ff.regs[g].low_limit <= st_ff.regs[g].high_limit)
        |=> (TRIM_OUT[g].enable == $past(REG_WDATA[trim_dac_pkg::CTRL_EN_BIT]));
    endproperty
    a_enable_follows_bit: assert property (p_enable_follows_bit)
      else $error("output enable does not follow control bit");

    property p_ctrl_reserved_zero;
      @(posedge MCLK) disable iff (RST)
        (REG_RD && REG_ADDR == trim_dac_pkg::CTRL_OFS[g]) |=> (REG_RDATA[7:3] == 5'h00);
    endproperty
    a_ctrl_reserved_zero: assert property (p_ctrl_reserved_zero)
      else $error("unused control bits read nonzero");

    property p_midscale_select;
      @(posedge MCLK) disable iff (RST)
        (REG_WR && REG_ADDR == trim_dac_pkg::CTRL_OFS[g])
        |=> (TRIM_OUT[g].midscale_voltage_select == $past(REG_WDATA[1:0]));
    endproperty
    a_midscale_select: assert property (p_midscale_select)
      else $error("midscale select does not follow control bits");

    property p_write_takes_effect;
      @(posedge MCLK) disable iff (RST)
        (REG_WR && REG_ADDR == trim_dac_pkg::CODE_OFS[g] &&
         REG_WDATA <= st_ff.regs[g].high_limit && REG_WDATA >= st_ff.regs[g].low_limit)
        |=> (TRIM_OUT[g].code == $past(REG_WDATA));
    endproperty
    a_write_takes_effect: assert property (p_write_takes_effect)
      else $error("in-range code not applied on the edge after its write");

    // output checks against the stored registers, independent of how they were written
    property p_enable_needs_bit;
      @(posedge MCLK) disable iff (RST)
        !st_ff.regs[g].trim_output_enable |-> !TRIM_OUT[g].enable;
    endproperty
    a_enable_needs_bit: assert property (p_enable_needs_bit)
      else $error("output enabled without its enable bit");

    property p_crossed_limits_off;
      @(posedge MCLK) disable iff (RST)
        (st_ff.regs[g].low_limit > st_ff.regs[g].high_limit) |-> !TRIM_OUT[g].enable;
    endproperty
    a_crossed_limits_off: assert property (p_crossed_limits_off)
      else $error("output enabled while limits are crossed");

    property p_enable_when_allowed;
      @(posedge MCLK) disable iff (RST)
        (st_ff.regs[g].trim_output_enable &&
         st_ff.regs[g].low_limit <= st_ff.regs[g].high_limit)
        |-> TRIM_OUT[g].enable;
    endproperty
    a_enable_when_allowed: assert property (p_enable_when_allowed)
      else $error("output held off although enable set and limits in order");

    property p_code_in_range_passes;
      @(posedge MCLK) disable iff (RST)
        (st_ff.regs[g].trim_code_bits <= st_ff.regs[g].high_limit &&
         st_ff.regs[g].trim_code_bits >= st_ff.regs[g].low_limit)
        |-> (TRIM_OUT[g].code == st_ff.regs[g].trim_code_bits);
    endproperty
    a_code_in_range_passes: assert property (p_code_in_range_passes)
      else $error("in-range code altered on its way out");

    // a code written above the upper limit lands as the limit on the next edge
    property p_clamp_high_write;
      @(posedge MCLK) disable iff (RST)
        (REG_WR && REG_ADDR == trim_dac_pkg::CODE_OFS[g] && REG_WDATA > st_ff.regs[g].high_limit)
        |=> (TRIM_OUT[g].code == $past(st_ff.regs[g].high_limit));
    endproperty
    a_clamp_high_write: assert property (p_clamp_high_write)
      else $error("written code above upper limit not clamped at once");

    // register readback, with one idle cycle between write and read
    property p_high_readback;
      @(posedge MCLK) disable iff (RST)
        (REG_WR && REG_ADDR == trim_dac_pkg::HI_OFS[g]) ##1 !REG_WR ##1
        (REG_RD && !REG_WR && REG_ADDR == trim_dac_pkg::HI_OFS[g])
        |=> (REG_RDATA == $past(REG_WDATA, 3));
    endproperty
    a_high_readback: assert property (p_high_readback)
      else $error("upper limit does not read back what was written");

    property p_low_readback;
      @(posedge MCLK) disable iff (RST)
        (REG_WR && REG_ADDR == trim_dac_pkg::LO_OFS[g]) ##1 !REG_WR ##1
        (REG_RD && !REG_WR && REG_ADDR == trim_dac_pkg::LO_OFS[g])
        |=> (REG_RDATA == $past(REG_WDATA, 3));
    endproperty
    a_low_readback: assert property (p_low_readback)
      else $error("lower limit does not read back what was written");

    property p_ctrl_readback;
      @(posedge MCLK) disable iff (RST)
        (REG_WR && REG_ADDR == trim_dac_pkg::CTRL_OFS[g]) ##1 !REG_WR ##1
        (REG_RD && !REG_WR && REG_ADDR == trim_dac_pkg::CTRL_OFS[g])
        |=> (REG_RDATA == {5'h00, $past(REG_WDATA[2:0], 3)});
    endproperty
    a_ctrl_readback: assert property (p_ctrl_readback)
      else $error("control register does not read back its low three bits");

    // without a control write the select must not drift
    property p_select_stable;
      @(posedge MCLK) disable iff (RST)
        !(REG_WR && REG_ADDR == trim_dac_pkg::CTRL_OFS[g])
        |=> $stable(TRIM_OUT[g].midscale_voltage_select);
    endproperty
    a_select_stable: assert property (p_select_stable)
      else $error("midscale select changed without a control write");

    // the applied code only moves when its code or a limit is written
    property p_code_stable;
      @(posedge MCLK) disable iff (RST)
        !(REG_WR && (REG_ADDR == trim_dac_pkg::CODE_OFS[g] ||
                     REG_ADDR == trim_dac_pkg::HI_OFS[g] ||
                     REG_ADDR == trim_dac_pkg::LO_OFS[g]))
        |=> $stable(TRIM_OUT[g].code);
    endproperty
    a_code_stable: assert property (p_code_stable)
      else $error("applied code changed without a code or limit write");

  end

  // read data stands until the next taken read, so a slow host may sample late
  property p_rdata_holds;
    @(posedge MCLK) disable iff (RST)
      !REG_RD |=> $stable(REG_RDATA);
  endproperty
  a_rdata_holds: assert property (p_rdata_holds)
    else $error("read data changed without a read");

endmodule

`default_nettype wire

/* rtl/trim_dac_pkg.sv */
// package: register map, reset values and carrier types of the trim converter control
package trim_dac_pkg;

  // number of trim channels handled here (channels 4, 5 and 6)
  localparam int unsigned NUM_CH = 3;

  // register offsets, channel 4 first
  localparam logic [7:0] TRIM_CH4_CONTROL    = 8'h53;
  localparam logic [7:0] TRIM_CH5_CONTROL    = 8'h54;
  localparam logic [7:0] TRIM_CH6_CONTROL    = 8'h55;
  localparam logic [7:0] TRIM_CH4_CODE       = 8'h5b;
  localparam logic [7:0] TRIM_CH5_CODE       = 8'h5c;
  localparam logic [7:0] TRIM_CH6_CODE       = 8'h5d;
  localparam logic [7:0] TRIM_CH4_HIGH_LIMIT = 8'h63;
  localparam logic [7:0] TRIM_CH5_HIGH_LIMIT = 8'h64;
  localparam logic [7:0] TRIM_CH6_HIGH_LIMIT = 8'h65;
  localparam logic [7:0] TRIM_CH4_LOW_LIMIT  = 8'h6b;
  localparam logic [7:0] TRIM_CH5_LOW_LIMIT  = 8'h6c;
  localparam logic [7:0] TRIM_CH6_LOW_LIMIT  = 8'h6d;

  // offsets grouped by channel index
  localparam logic [NUM_CH-1:0][7:0] CTRL_OFS = {TRIM_CH6_CONTROL, TRIM_CH5_CONTROL, TRIM_CH4_CONTROL};
  localparam logic [NUM_CH-1:0][7:0] CODE_OFS = {TRIM_CH6_CODE, TRIM_CH5_CODE, TRIM_CH4_CODE};
  localparam logic [NUM_CH-1:0][7:0] HI_OFS   = {TRIM_CH6_HIGH_LIMIT, TRIM_CH5_HIGH_LIMIT, TRIM_CH4_HIGH_LIMIT};
  localparam logic [NUM_CH-1:0][7:0] LO_OFS   = {TRIM_CH6_LOW_LIMIT, TRIM_CH5_LOW_LIMIT, TRIM_CH4_LOW_LIMIT};

  // control register field positions
  localparam int unsigned CTRL_EN_BIT  = 2;
  localparam int unsigned CTRL_SEL_MSB = 1;

  // values after reset
  localparam logic [7:0] MIDSCALE_CODE = 8'h7f;
  localparam logic [7:0] HI_RESET      = 8'hff;
  localparam logic [7:0] LO_RESET      = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // midscale voltage select encodings: 1.25 V, 1.0 V, 0.8 V, 0.6 V
  typedef enum logic [1:0] {
    MID_1V25,
    MID_1V00,
    MID_0V80,
    MID_0V60
  } midscale_voltage_select_t;

  // per-channel programmed state
  typedef struct packed {
    logic [7:0]               trim_code_bits;
    logic [7:0]               high_limit;
    logic [7:0]               low_limit;
    logic                     trim_output_enable;
    midscale_voltage_select_t midscale_voltage_select;
  } chan_regs_t;

  // per-channel drive toward the converter stage
  typedef struct packed {
    logic [7:0]               code;
    logic                     enable;
    midscale_voltage_select_t midscale_voltage_select;
  } trim_out_t;

  // complete state of the control block
  typedef struct packed {
    chan_regs_t [NUM_CH-1:0] regs;
    trim_out_t  [NUM_CH-1:0] outs;
    logic       [7:0]        rdata;
  } trim_state_t;

endpackage

/* verification/tb_top.sv */
// testbench: register port and trim output checks of the trim converter control block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic                                             MCLK = 1'b0;
  logic                                             RST = 1'b1;
  logic [7:0]                                       REG_ADDR = 8'h00;
  logic                                             REG_WR = 1'b0;
  logic [7:0]                                       REG_WDATA = 8'h00;
  logic                                             REG_RD = 1'b0;
  logic [7:0]                                       REG_RDATA;
  trim_dac_pkg::trim_out_t [trim_dac_pkg::NUM_CH-1:0] TRIM_OUT;
  int                                               miscompares = 0;
  int                                               cmp_count = 0;

  trim_dac_code_limit_control i_dut (
    .MCLK      (MCLK),
    .RST       (RST),
    .REG_ADDR  (REG_ADDR),
    .REG_WR    (REG_WR),
    .REG_WDATA (REG_WDATA),
    .REG_RD    (REG_RD),
    .REG_RDATA (REG_RDATA),
    .TRIM_OUT  (TRIM_OUT)
  );

  // 200 MHz clock
  initial begin
    forever #2.5 MCLK = ~MCLK;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
      miscompares++;
    end
  endtask

  // one write pulse, outputs sampled once the taking edge has landed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge MCLK);
    REG_WR <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge MCLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1;
    chk(REG_RDATA, exp, "read data");
  endtask

  // reference clamp, high limit checked first, unsigned compare
  function automatic logic [7:0] clamp(input logic [7:0] c, input logic [7:0] h, input logic [7:0] l);
    return (c > h) ? h : ((c < l) ? l : c);
  endfunction

  task automatic t_reset;
    for (int ch = 0; ch < 3; ch++) begin
      rd(trim_dac_pkg::CTRL_OFS[ch], 8'h00);
      rd(trim_dac_pkg::CODE_OFS[ch], 8'h7f);
      rd(trim_dac_pkg::HI_OFS[ch], 8'hff);
      rd(trim_dac_pkg::LO_OFS[ch], 8'h00);
      chk(TRIM_OUT[ch].code, 8'h7f, "reset code");
      chk({7'h00, TRIM_OUT[ch].enable}, 8'h00, "reset enable");
      chk({6'h00, TRIM_OUT[ch].midscale_voltage_select}, 8'h00, "reset select");
    end
  endtask

  // codes around both limits, 0x80 catches a signed compare
  task automatic t_clamp;
    logic [7:0] codes [9];
    codes = '{8'hff, 8'hc1, 8'hc0, 8'hbf, 8'h80, 8'h41, 8'h40, 8'h3f, 8'h00};
    for (int ch = 0; ch < 3; ch++) begin
      wr(trim_dac_pkg::HI_OFS[ch], 8'hc0);
      rd(trim_dac_pkg::HI_OFS[ch], 8'hc0);
      wr(trim_dac_pkg::LO_OFS[ch], 8'h40);
      foreach (codes[i]) begin
        wr(trim_dac_pkg::CODE_OFS[ch], codes[i]);
        chk(TRIM_OUT[ch].code, clamp(codes[i], 8'hc0, 8'h40), "clamped code");
        rd(trim_dac_pkg::CODE_OFS[ch], codes[i]);
      end
    end
  endtask

  // crossed limits force the output off whatever the enable bit says
  task automatic t_safety;
    for (int ch = 0; ch < 3; ch++) begin
      wr(trim_dac_pkg::CTRL_OFS[ch], 8'h04);
      chk({7'h00, TRIM_OUT[ch].enable}, 8'h01, "enable on");
      wr(trim_dac_pkg::LO_OFS[ch], 8'hc1);
      chk({7'h00, TRIM_OUT[ch].enable}, 8'h00, "crossed limits");
      rd(trim_dac_pkg::LO_OFS[ch], 8'hc1);
      wr(trim_dac_pkg::LO_OFS[ch], 8'hc0);
      chk({7'h00, TRIM_OUT[ch].enable}, 8'h01, "equal limits");
      wr(trim_dac_pkg::CTRL_OFS[ch], 8'h00);
      chk({7'h00, TRIM_OUT[ch].enable}, 8'h00, "enable off");
    end
  endtask

  task automatic t_ctrl;
    for (int ch = 0; ch < 3; ch++) begin
      for (int s = 0; s < 4; s++) begin
        wr(trim_dac_pkg::CTRL_OFS[ch], 8'hfc | 8'(s));
        chk({6'h00, TRIM_OUT[ch].midscale_voltage_select}, 8'(s), "select");
        chk({7'h00, TRIM_OUT[ch].enable}, 8'h01, "enable");
        rd(trim_dac_pkg::CTRL_OFS[ch], 8'h04 | 8'(s));
      end
    end
  endtask

  // writes outside the map must leave every register alone
  task automatic t_unmapped;
    wr(8'h56, 8'haa);
    wr(8'h5e, 8'h11);
    rd(8'h56, 8'h00);
    rd(8'h5e, 8'h00);
    rd(trim_dac_pkg::CODE_OFS[2], 8'h00);
    chk(TRIM_OUT[2].code, 8'hc0, "code kept");
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
    t_reset();
    t_clamp();
    t_safety();
    t_ctrl();
    t_unmapped();
    final_report();
  end
endmodule

`default_nettype wire
